// >>> include/rtccv_pkg.sv
// Constants, register map and shared helpers of the calendar value block.
// Assumes a 32-bit AXI4-Lite slave with each register in the low 16 bits of a word.
package rtccv_pkg;
	localparam logic [7:0] RTCCV_OFF_YEAR = 8'h00;
	localparam logic [7:0] RTCCV_OFF_MD = 8'h04;
	localparam logic [7:0] RTCCV_OFF_WH = 8'h08;
	localparam logic [7:0] RTCCV_OFF_MS = 8'h0C;
	localparam logic [7:0] RTCCV_OFF_AMD = 8'h10;
	localparam logic [7:0] RTCCV_OFF_AWH = 8'h14;
	localparam logic [7:0] RTCCV_OFF_AMS = 8'h18;
	localparam logic [7:0] RTCCV_OFF_CFG = 8'h1C;
	localparam logic [7:0] RTCCV_OFF_WIN_HI = 8'h20;
	localparam logic [7:0] RTCCV_OFF_WIN_LO = 8'h24;

	localparam logic [15:0] RTCCV_MASK_MD = 16'h1F3F;
	localparam logic [15:0] RTCCV_MASK_WH = 16'h073F;
	localparam logic [15:0] RTCCV_MASK_MS = 16'h7F7F;

	localparam int RTCCV_ENABLE_BIT = 15;
	localparam int RTCCV_UNLOCK_BIT = 13;
	localparam int RTCCV_SYNC_BIT = 12;
	localparam int RTCCV_HALF_BIT = 11;
	localparam int RTCCV_PTR_LSB = 8;
	localparam logic [1:0] RTCCV_PTR_RESET = 2'h0;
	localparam logic [7:0] RTCCV_CAL_RESET = 8'h00;

	localparam int RTCCV_XTAL_HZ = 32768;
	localparam logic signed [16:0] RTCCV_SEC_LAST = 17'(RTCCV_XTAL_HZ - 1);
	localparam logic signed [16:0] RTCCV_HALF_LAST = 17'(RTCCV_XTAL_HZ / 2 - 1);
	localparam logic signed [16:0] RTCCV_SYNC_FROM = 17'(RTCCV_XTAL_HZ - 32);

	localparam logic [7:0] RTCCV_SEC_TOP = 8'h59;
	localparam logic [7:0] RTCCV_HOUR_TOP = 8'h23;
	localparam logic [7:0] RTCCV_MONTH_TOP = 8'h12;
	localparam logic [7:0] RTCCV_YEAR_TOP = 8'h99;
	localparam logic [7:0] RTCCV_ZERO = 8'h00;
	localparam logic [7:0] RTCCV_ONE = 8'h01;
	localparam logic [2:0] RTCCV_WDAY_TOP = 3'h6;

	localparam logic [1:0] RTCCV_RESP_OKAY = 2'h0;
	localparam logic [1:0] RTCCV_RESP_SLVERR = 2'h2;

	typedef enum logic [3:0]
	{
		RTCCV_R_YEAR = 4'h0,
		RTCCV_R_MD = 4'h1,
		RTCCV_R_WH = 4'h2,
		RTCCV_R_MS = 4'h3,
		RTCCV_R_AMD = 4'h4,
		RTCCV_R_AWH = 4'h5,
		RTCCV_R_AMS = 4'h6,
		RTCCV_R_CFG = 4'h7,
		RTCCV_R_WIN_HI = 4'h8,
		RTCCV_R_WIN_LO = 4'h9,
		RTCCV_R_NONE = 4'hF
	} rtccv_reg_t;

	function automatic rtccv_reg_t rtccv_decode(input logic [7:0] addr);
		rtccv_reg_t r;
		r = RTCCV_R_NONE;
		if (addr[1:0] == 2'h0)
		begin
			case (addr)
				RTCCV_OFF_YEAR: r = RTCCV_R_YEAR;
				RTCCV_OFF_MD: r = RTCCV_R_MD;
				RTCCV_OFF_WH: r = RTCCV_R_WH;
				RTCCV_OFF_MS: r = RTCCV_R_MS;
				RTCCV_OFF_AMD: r = RTCCV_R_AMD;
				RTCCV_OFF_AWH: r = RTCCV_R_AWH;
				RTCCV_OFF_AMS: r = RTCCV_R_AMS;
				RTCCV_OFF_CFG: r = RTCCV_R_CFG;
				RTCCV_OFF_WIN_HI: r = RTCCV_R_WIN_HI;
				RTCCV_OFF_WIN_LO: r = RTCCV_R_WIN_LO;
				default: r = RTCCV_R_NONE;
			endcase
		end
		return r;
	endfunction : rtccv_decode

	// Byte-lane merge of a bus write into a 16-bit register
	function automatic logic [15:0] rtccv_merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] m;
		m[7:0] = strb[0] ? data[7:0] : old[7:0];
		m[15:8] = strb[1] ? data[15:8] : old[15:8];
		return m;
	endfunction : rtccv_merge
endpackage : rtccv_pkg

// >>> hw/rtccv_pin_sync.sv
// Two-stage synchroniser for the crystal pin with a rising-edge pulse.
// Assumes the crystal is far slower than aclk so no edge is missed.
module rtccv_pin_sync
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign rise = sync_reg & ~last_reg;
endmodule : rtccv_pin_sync

// >>> hw/rtccv_bcd_pair.sv
// Two-digit BCD counter with load, wrap limit and restart value.
// Assumes the caller keeps load and tick mutually meaningful; load wins.
module rtccv_bcd_pair #(parameter int TW = 3)
(
	input wire logic aclk,
	input wire logic tick,
	input wire logic load,
	input wire logic [TW+3:0] load_value,
	input wire logic [7:0] top,
	input wire logic [7:0] bottom,
	output logic [TW+3:0] value,
	output logic wrap
);
	// Digits carry no reset: contents are undefined until software loads them
	logic [TW+3:0] value_reg;
	logic at_top;

	// At or past the limit, so a day set beyond a short month still wraps
	assign at_top = value_reg >= top[TW+3:0];
	assign wrap = tick & at_top;
	assign value = value_reg;

	always_ff @(posedge aclk)
	begin
		if (load)
			value_reg <= load_value;
		else if (tick)
		begin
			if (at_top)
				value_reg <= bottom[TW+3:0];
			else if (value_reg[3:0] == 4'h9)
				value_reg <= {TW'(value_reg[TW+3:4] + 1'b1), 4'h0};
			else
				value_reg[3:0] <= value_reg[3:0] + 4'h1;
		end
	end
endmodule : rtccv_bcd_pair

// >>> hw/rtccv_calendar_regs.sv
// Calendar value registers, alarm value registers and drift trim of the clock unit.
// Assumes an AXI4-Lite master on aclk and a 32.768 kHz crystal on xtal_clk_in.
// Contract
// [RQ1] Year is two BCD digits, upper byte zero
// [RQ2] Year writes need the unlock bit set
// [RQ3] Month tens bit 12, units bits 11-8
// [RQ4] Day tens bits 5-4, units bits 3-0
// [RQ5] Weekday is bits 10-8, values 0-6
// [RQ6] Hour tens bits 5-4, units bits 3-0
// [RQ7] Minutes in upper byte, tens 14-12
// [RQ8] Seconds in lower byte, tens 6-4
// [RQ9] Month/day, weekday/hour writes need unlock bit
// [RQ10] Alarm registers mirror time register digit layout
// [RQ11] Unimplemented bits read zero, ignore writes
// [RQ12] Digit bits are not reset
// [RQ13] Signed trim times four added once per minute
// [RQ14] Software measures crystal error, loads trim byte
// [RQ15] Unlock bit clear blocks windowed time writes
// [RQ16] Window pointer decrements on high access, stops 00
// [RQ17] Trim step four pulses, +508 to -512
// [RQ18] Minute/second low byte write clears half flag
// [RQ19] Digits cascade as a BCD calendar
module rtccv_calendar_regs
	import rtccv_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic xtal_clk_in
);
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic enable_reg, time_write_unlock, half_second_flag;
	logic [1:0] value_window_pointer;
	logic [7:0] cal_reg;
	logic signed [16:0] presc_reg, cal_step;
	logic [2:0] weekday_digit;
	logic [15:0] alarm_month_day, alarm_weekday_hour, alarm_minute_second;

	logic xtal_rise, do_write, read_take, time_wr, load_ms, load_wh, load_md, load_yr;
	rtccv_reg_t wr_sel, wr_reg, rd_sel;
	logic [15:0] wr_old, wr_word, window_word;
	logic [31:0] rd_word;
	logic count_tick, sec_tick, half_tick, rollover_near;
	logic [6:0] sec_val, min_val;
	logic [5:0] hour_val, day_val;
	logic [4:0] month_val;
	logic [7:0] year_val, day_top;
	logic sec_wrap, min_wrap, hour_wrap, day_wrap, month_wrap;
	logic [15:0] year_value, month_day_value, weekday_hour_value, minute_second_value;

	// Pointer codes to the value register behind both windows
	function automatic rtccv_reg_t ptr_target(input logic [1:0] ptr);
		rtccv_reg_t r;
		case (ptr)
			2'h0: r = RTCCV_R_MS;
			2'h1: r = RTCCV_R_WH;
			2'h2: r = RTCCV_R_MD;
			default: r = RTCCV_R_YEAR;
		endcase
		return r;
	endfunction : ptr_target

	// Leap test on a BCD year: divisible by four
	function automatic logic [7:0] month_length(input logic [4:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			5'h02: month_length = leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: month_length = 8'h30;
			default: month_length = 8'h31;
		endcase
	endfunction : month_length

	rtccv_pin_sync u_xtal_sync
	(
		.aclk(aclk), .aresetn(aresetn), .pin(xtal_clk_in), .rise(xtal_rise)
	);

	// Bus write side: address and data captured in either order
	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
	assign do_write = aw_held_reg & w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
		else if (do_write)
			w_held_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RTCCV_RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_sel == RTCCV_R_NONE) ? RTCCV_RESP_SLVERR : RTCCV_RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	// Write steering: windows land on the register the pointer names
	assign wr_sel = rtccv_decode(aw_addr_reg);
	assign wr_reg = (wr_sel == RTCCV_R_WIN_HI || wr_sel == RTCCV_R_WIN_LO)
		? ptr_target(value_window_pointer) : wr_sel;

	always_comb
	begin
		case (wr_reg)
			RTCCV_R_YEAR: wr_old = year_value;
			RTCCV_R_MD: wr_old = month_day_value;
			RTCCV_R_WH: wr_old = weekday_hour_value;
			RTCCV_R_MS: wr_old = minute_second_value;
			RTCCV_R_AMD: wr_old = alarm_month_day;
			RTCCV_R_AWH: wr_old = alarm_weekday_hour;
			default: wr_old = alarm_minute_second;
		endcase
	end

	assign wr_word = rtccv_merge(wr_old, w_data_reg, w_strb_reg);
	// Every time value register, direct or windowed, is locked without unlock
	assign time_wr = do_write & time_write_unlock; // [RQ2] [RQ9] [RQ15]

	// Configuration and trim register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enable_reg <= 1'b0;
			time_write_unlock <= 1'b0;
			cal_reg <= RTCCV_CAL_RESET;
		end
		else if (do_write && wr_sel == RTCCV_R_CFG)
		begin
			if (w_strb_reg[1])
			begin
				time_write_unlock <= w_data_reg[RTCCV_UNLOCK_BIT];
				if (time_write_unlock)
					enable_reg <= w_data_reg[RTCCV_ENABLE_BIT];
			end
			if (w_strb_reg[0])
				cal_reg <= w_data_reg[7:0]; // [RQ14]
		end
	end

	// Pointer: config write wins over a same-cycle window access
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			value_window_pointer <= RTCCV_PTR_RESET;
		else if (do_write && wr_sel == RTCCV_R_CFG && w_strb_reg[1])
			value_window_pointer <= w_data_reg[RTCCV_PTR_LSB+1:RTCCV_PTR_LSB];
		else if (((do_write && wr_sel == RTCCV_R_WIN_HI)
			|| (read_take && rd_sel == RTCCV_R_WIN_HI))
			&& value_window_pointer != 2'h0)
			value_window_pointer <= value_window_pointer - 2'h1; // [RQ16]
	end

	// Time base: prescaler of crystal edges with once-a-minute trim
	assign count_tick = enable_reg & xtal_rise;
	assign sec_tick = count_tick & (presc_reg == RTCCV_SEC_LAST);
	assign half_tick = count_tick & (presc_reg == RTCCV_HALF_LAST);
	assign rollover_near = presc_reg >= RTCCV_SYNC_FROM;
	// Positive trim shortens the minute, negative lengthens it
	assign cal_step = {{7{cal_reg[7]}}, cal_reg, 2'b00}; // [RQ13] [RQ17]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			presc_reg <= 17'sh00000;
		else if (sec_tick)
			presc_reg <= sec_wrap ? cal_step : 17'sh00000; // [RQ13]
		else if (count_tick)
			presc_reg <= presc_reg + 17'sh00001;
	end

	// Set wins over the write clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			half_second_flag <= 1'b0;
		else if (half_tick)
			half_second_flag <= 1'b1;
		else if (sec_tick)
			half_second_flag <= 1'b0;
		else if (time_wr && wr_reg == RTCCV_R_MS && w_strb_reg[0])
			half_second_flag <= 1'b0; // [RQ18]
	end

	// Calendar cascade
	assign day_top = month_length(month_val, year_val);
	assign load_ms = time_wr && wr_reg == RTCCV_R_MS;
	assign load_wh = time_wr && wr_reg == RTCCV_R_WH;
	assign load_md = time_wr && wr_reg == RTCCV_R_MD;
	assign load_yr = time_wr && wr_reg == RTCCV_R_YEAR;

	rtccv_bcd_pair #(.TW(3)) u_sec
	(
		.aclk(aclk), .tick(sec_tick), .load(load_ms), .load_value(wr_word[6:0]), // [RQ8]
		.top(RTCCV_SEC_TOP), .bottom(RTCCV_ZERO), .value(sec_val), .wrap(sec_wrap)
	);
	rtccv_bcd_pair #(.TW(3)) u_min
	(
		.aclk(aclk), .tick(sec_wrap), .load(load_ms), .load_value(wr_word[14:8]), // [RQ7]
		.top(RTCCV_SEC_TOP), .bottom(RTCCV_ZERO), .value(min_val), .wrap(min_wrap) // [RQ19]
	);
	rtccv_bcd_pair #(.TW(2)) u_hour
	(
		.aclk(aclk), .tick(min_wrap), .load(load_wh), .load_value(wr_word[5:0]), // [RQ6]
		.top(RTCCV_HOUR_TOP), .bottom(RTCCV_ZERO), .value(hour_val), .wrap(hour_wrap)
	);
	rtccv_bcd_pair #(.TW(2)) u_day
	(
		.aclk(aclk), .tick(hour_wrap), .load(load_md), .load_value(wr_word[5:0]), // [RQ4]
		.top(day_top), .bottom(RTCCV_ONE), .value(day_val), .wrap(day_wrap)
	);
	rtccv_bcd_pair #(.TW(1)) u_month
	(
		.aclk(aclk), .tick(day_wrap), .load(load_md), .load_value(wr_word[12:8]), // [RQ3]
		.top(RTCCV_MONTH_TOP), .bottom(RTCCV_ONE), .value(month_val), .wrap(month_wrap)
	);
	rtccv_bcd_pair #(.TW(4)) u_year
	(
		.aclk(aclk), .tick(month_wrap), .load(load_yr), .load_value(wr_word[7:0]), // [RQ1]
		.top(RTCCV_YEAR_TOP), .bottom(RTCCV_ZERO), .value(year_val), .wrap()
	);

	// Weekday has no reset either; it follows the day carry
	always_ff @(posedge aclk)
	begin
		if (time_wr && wr_reg == RTCCV_R_WH)
			weekday_digit <= wr_word[10:8]; // [RQ5] [RQ12]
		else if (hour_wrap)
			weekday_digit <= (weekday_digit >= RTCCV_WDAY_TOP) ? 3'h0
				: weekday_digit + 3'h1; // [RQ19]
	end

	// Alarm values keep the time layout; only the masked bits are stored
	always_ff @(posedge aclk)
	begin
		if (time_wr && wr_reg == RTCCV_R_AMD)
			alarm_month_day <= wr_word & RTCCV_MASK_MD; // [RQ10] [RQ12]
		if (time_wr && wr_reg == RTCCV_R_AWH)
			alarm_weekday_hour <= wr_word & RTCCV_MASK_WH; // [RQ10]
		if (do_write && wr_reg == RTCCV_R_AMS)
			alarm_minute_second <= wr_word & RTCCV_MASK_MS; // [RQ10] [RQ11]
	end

	// Read words with unimplemented bits forced to zero
	assign year_value = {8'h00, year_val}; // [RQ1] [RQ11]
	assign month_day_value = {3'h0, month_val, 2'h0, day_val}; // [RQ11]
	assign weekday_hour_value = {5'h00, weekday_digit, 2'h0, hour_val}; // [RQ11]
	assign minute_second_value = {1'b0, min_val, 1'b0, sec_val}; // [RQ11]

	always_comb
	begin
		case (value_window_pointer)
			2'h0: window_word = minute_second_value;
			2'h1: window_word = weekday_hour_value;
			2'h2: window_word = month_day_value;
			default: window_word = year_value;
		endcase
	end

	assign rd_sel = rtccv_decode(s_axi_araddr);

	always_comb
	begin
		rd_word = 32'h00000000;
		case (rd_sel)
			RTCCV_R_YEAR: rd_word[15:0] = year_value;
			RTCCV_R_MD: rd_word[15:0] = month_day_value;
			RTCCV_R_WH: rd_word[15:0] = weekday_hour_value;
			RTCCV_R_MS: rd_word[15:0] = minute_second_value;
			RTCCV_R_AMD: rd_word[15:0] = alarm_month_day;
			RTCCV_R_AWH: rd_word[15:0] = alarm_weekday_hour;
			RTCCV_R_AMS: rd_word[15:0] = alarm_minute_second;
			RTCCV_R_CFG:
			begin
				rd_word[RTCCV_ENABLE_BIT] = enable_reg;
				rd_word[RTCCV_UNLOCK_BIT] = time_write_unlock;
				rd_word[RTCCV_SYNC_BIT] = rollover_near;
				rd_word[RTCCV_HALF_BIT] = half_second_flag;
				rd_word[RTCCV_PTR_LSB+1:RTCCV_PTR_LSB] = value_window_pointer;
				rd_word[7:0] = cal_reg;
			end
			RTCCV_R_WIN_HI, RTCCV_R_WIN_LO: rd_word[15:0] = window_word;
			default: rd_word = 32'h00000000;
		endcase
	end

	// Bus read side: one read in flight, data registered at acceptance
	assign s_axi_arready = ~rvalid_reg;
	assign read_take = s_axi_arvalid & ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RTCCV_RESP_OKAY;
		end
		else if (read_take)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= (rd_sel == RTCCV_R_NONE) ? RTCCV_RESP_SLVERR : RTCCV_RESP_OKAY;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end
endmodule : rtccv_calendar_regs

// >>> verification/rtccv_calendar_regs_checker.sv
// Bus handshake and register layout assertions for the calendar value block.
// Bound into rtccv_calendar_regs; watches its bus ports only.
module rtccv_calendar_regs_checker
	import rtccv_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [7:0] wr_addr_reg;
	logic [7:0] rd_addr_reg;

	// Address of the transfer whose answer is pending
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wr_addr_reg <= 8'h00;
		else if (s_axi_awvalid && s_axi_awready)
			wr_addr_reg <= s_axi_awaddr;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_addr_reg <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr_reg <= s_axi_araddr;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_WR_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel open while response pending");
	AST_RD_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open while data pending");
	AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_B_CODE: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
		(rtccv_decode(wr_addr_reg) == RTCCV_R_NONE ? RTCCV_RESP_SLVERR : RTCCV_RESP_OKAY))
		else $error("wrong write response code");
	AST_R_CODE: assert property (s_axi_rvalid |-> s_axi_rresp ==
		(rtccv_decode(rd_addr_reg) == RTCCV_R_NONE ? RTCCV_RESP_SLVERR : RTCCV_RESP_OKAY))
		else $error("wrong read response code");
	AST_YEAR_BITS: assert property (s_axi_rvalid && rd_addr_reg == RTCCV_OFF_YEAR
		|-> s_axi_rdata[31:8] == 24'h000000) else $error("year upper bits not zero");
	AST_MD_BITS: assert property (s_axi_rvalid && (rd_addr_reg == RTCCV_OFF_MD
		|| rd_addr_reg == RTCCV_OFF_AMD) |-> (s_axi_rdata & ~{16'h0000, RTCCV_MASK_MD}) == 32'h0)
		else $error("month/day spare bits set");
	AST_WH_BITS: assert property (s_axi_rvalid && (rd_addr_reg == RTCCV_OFF_WH
		|| rd_addr_reg == RTCCV_OFF_AWH) |-> (s_axi_rdata & ~{16'h0000, RTCCV_MASK_WH}) == 32'h0
		&& s_axi_rdata[10:8] <= RTCCV_WDAY_TOP) else $error("weekday/hour field wrong");
	AST_MS_BITS: assert property (s_axi_rvalid && (rd_addr_reg == RTCCV_OFF_MS
		|| rd_addr_reg == RTCCV_OFF_AMS) |-> (s_axi_rdata & ~{16'h0000, RTCCV_MASK_MS}) == 32'h0)
		else $error("minute/second spare bits set");

	cover property (s_axi_bvalid && s_axi_bresp == RTCCV_RESP_SLVERR);
	cover property (s_axi_rvalid && rd_addr_reg == RTCCV_OFF_WIN_HI);
	cover property (s_axi_rvalid && s_axi_rdata[RTCCV_HALF_BIT]);
endmodule : rtccv_calendar_regs_checker

bind rtccv_calendar_regs rtccv_calendar_regs_checker rtccv_calendar_regs_checker_i
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// >>> verification/rtccv_calendar_regs_tb_top.sv
// Self-checking bench for the calendar value block over AXI4-Lite.
// Assumes a free-running crystal of roughly 2.3 MHz to keep the half-second wait short.
module rtccv_calendar_regs_tb_top
	import rtccv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [1:0] OKAY = RTCCV_RESP_OKAY;
	localparam logic [1:0] ERR = RTCCV_RESP_SLVERR;
	logic aclk = 1'h0, aresetn = 1'h0, xtal_clk_in = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] bq[$];
	logic [65:0] rq[$];
	logic [65:0] rexp;
	logic [15:0] shadow [7];
	logic [15:0] v;
	logic [15:0] msk [7] = '{16'h00FF, RTCCV_MASK_MD, RTCCV_MASK_WH, RTCCV_MASK_MS,
		RTCCV_MASK_MD, RTCCV_MASK_WH, RTCCV_MASK_MS};
	int fail_count = 0, check_count = 0, i;

	always #50 aclk = ~aclk;
	// Odd half period keeps the crystal unrelated to aclk
	always #213 xtal_clk_in = ~xtal_clk_in;

	rtccv_calendar_regs rtccv_calendar_regs_i
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.xtal_clk_in(xtal_clk_in)
	);

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		check_count++;
		if ((got & m) !== (exp & m))
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		bq.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			aw_done = aw_done | (s_axi_awready === 1'h1);
			w_done = w_done | (s_axi_wready === 1'h1);
			if (aw_done)
				s_axi_awvalid <= 1'h0;
			if (w_done)
				s_axi_wvalid <= 1'h0;
		end
		// Late bready makes the slave hold its response
		repeat ($urandom_range(2, 0)) @(posedge aclk);
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] er);
		rq.push_back({er, m, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		repeat ($urandom_range(2, 0)) @(posedge aclk);
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rd

	function automatic logic [7:0] rbcd(input int top);
		int n;
		n = $urandom_range(top, 0);
		return 8'((n / 10) * 16 + n % 10);
	endfunction : rbcd

	// Legal digit values only; the register keeps whatever is loaded
	function automatic logic [15:0] rval(input int r);
		case (r)
			0: return {8'h00, rbcd(99)};
			1, 4: return {rbcd(12), rbcd(31)};
			2, 5: return {5'h00, 3'($urandom_range(6, 0)), rbcd(23)};
			default: return {rbcd(59), rbcd(59)};
		endcase
	endfunction : rval

	always @(posedge aclk)
	begin
		if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1)
			cmp({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()}, 32'h3);
		if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1)
		begin
			rexp = rq.pop_front();
			cmp(s_axi_rdata, rexp[31:0], rexp[63:32]);
			cmp({30'h0, s_axi_rresp}, {30'h0, rexp[65:64]}, 32'h3);
		end
	end

	initial
	begin
		repeat (90000) @(posedge aclk);
		fail_count++;
		close_out();
	end

	initial
	begin
		void'($urandom(31949));
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(RTCCV_OFF_CFG, 32'h0, ALL, OKAY);
		$display("test reset_state done");
		wr(RTCCV_OFF_CFG, 32'h2000, 4'hF, OKAY);
		for (int k = 0; k < 21; k++)
		begin
			i = k % 7;
			v = rval(i);
			shadow[i] = v;
			wr(8'(i * 4), {16'hFFFF, v | ~msk[i]}, 4'hF, OKAY);
			rd(8'(i * 4), {16'h0000, v}, ALL, OKAY);
		end
		$display("test field_layout done");
		wr(RTCCV_OFF_CFG, 32'h0, 4'hF, OKAY);
		for (int k = 0; k < 6; k++)
			wr(8'(k * 4), {16'h0000, rval(k)}, 4'hF, OKAY);
		wr(RTCCV_OFF_WIN_HI, 32'h0, 4'hF, OKAY);
		for (int k = 0; k < 6; k++)
			rd(8'(k * 4), {16'h0000, shadow[k]}, ALL, OKAY);
		$display("test write_lock done");
		wr(RTCCV_OFF_AMS, 32'h5959, 4'hF, OKAY);
		wr(RTCCV_OFF_AMS, 32'h3412, 4'h1, OKAY);
		rd(RTCCV_OFF_AMS, 32'h5912, ALL, OKAY);
		wr(8'h30, 32'h1, 4'hF, ERR);
		wr(8'h02, 32'h1, 4'hF, ERR);
		rd(8'h30, 32'h0, ALL, ERR);
		$display("test lanes_unmapped done");
		wr(RTCCV_OFF_CFG, 32'h2300, 4'hF, OKAY);
		rd(RTCCV_OFF_WIN_LO, {16'h0000, shadow[0]}, ALL, OKAY);
		for (int k = 0; k < 5; k++)
			rd(RTCCV_OFF_WIN_HI, {16'h0000, shadow[k < 4 ? k : 3]}, ALL, OKAY);
		rd(RTCCV_OFF_CFG, 32'h2000, ALL, OKAY);
		$display("test window_pointer done");
		wr(RTCCV_OFF_CFG, 32'hA07F, 4'hF, OKAY);
		// About 16670 crystal rises: past half a second, well short of a whole one
		repeat (71000) @(posedge aclk);
		rd(RTCCV_OFF_CFG, 32'hA87F, ALL, OKAY);
		v = rval(3);
		wr(RTCCV_OFF_WIN_HI, {16'h0000, v}, 4'h1, OKAY);
		rd(RTCCV_OFF_CFG, 32'hA07F, ALL, OKAY);
		rd(RTCCV_OFF_MS, {16'h0000, shadow[3][15:8], v[7:0]}, ALL, OKAY);
		$display("test half_second done");
		close_out();
	end
endmodule : rtccv_calendar_regs_tb_top
